/* design/rtcc_regs.vh */
`ifndef RTCC_REGS_VH
`define RTCC_REGS_VH

// Register byte offsets
`define RTCC_OFS_CTRL      8'h18
`define RTCC_OFS_MASK      8'h1C
`define RTCC_OFS_RAW       8'h20
`define RTCC_OFS_MASKED    8'h24
`define RTCC_OFS_CLEAR     8'h28

// Control register fields
`define RTCC_DIV_LSB       0
`define RTCC_DIV_MSB       14
`define RTCC_TRIM_LSB      16
`define RTCC_TRIM_MSB      25
`define RTCC_LOCK_BIT      26

// Interrupt bit positions
`define RTCC_IRQ_CAL       0
`define RTCC_IRQ_CNT       1

// Reset values
`define RTCC_DIV_RST       15'h7FFF
`define RTCC_TRIM_RST      10'h000
`define RTCC_MASK_RST      2'h0

// Trim window length in slow-clock cycles
`define RTCC_TRIM_WINDOW   10'h3FF

// AXI responses
`define RTCC_RESP_OKAY     2'h0
`define RTCC_RESP_SLVERR   2'h2

`endif

/* design/rtcc_tick_gen.v */
`timescale 1ns/1ps
`include "rtcc_regs.vh"

// Divides the slow-clock enable into the 1 Hz tick, with pulse deletion.
module rtcc_tick_gen #(
    parameter DIV_W  = 15,
    parameter TRIM_W = 10
)(
    input  wire              clk_sys,
    input  wire              nrst,
    input  wire              slowEdge,
    input  wire [DIV_W-1:0]  tickDivider,
    input  wire [TRIM_W-1:0] trimDeleteCount,
    output reg               oneHzTickTimer,
    output reg               oneHzTickCal
);

    reg  [DIV_W-1:0]  divCnt_r;
    reg  [TRIM_W-1:0] winCnt_r;
    wire              keepEdge;
    wire              wrapNow;

    // Delete the first N slow pulses of every 1023-cycle window
    assign keepEdge = slowEdge && (winCnt_r >= trimDeleteCount);
    assign wrapNow  = (divCnt_r >= tickDivider);

    ////////////////////////////////////////////////////////////////////////
    // Trim window and divider counters
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            winCnt_r       <= {TRIM_W{1'b0}};
            divCnt_r       <= {DIV_W{1'b0}};
            oneHzTickTimer <= 1'b0;
            oneHzTickCal   <= 1'b0;
        end
        else
        begin
            oneHzTickTimer <= 1'b0;
            oneHzTickCal   <= 1'b0;
            if (slowEdge)
            begin
                // Zero trim deletes nothing; max deletes whole window
                if (winCnt_r == `RTCC_TRIM_WINDOW - 10'h001)
                    winCnt_r <= {TRIM_W{1'b0}};
                else
                    winCnt_r <= winCnt_r + 10'h001;
            end
            if (tickDivider == {DIV_W{1'b0}})
            begin
                // Timer tick follows slow clock, calendar tick stops
                divCnt_r       <= {DIV_W{1'b0}};
                oneHzTickTimer <= slowEdge;
            end
            else if (keepEdge)
            begin
                // Divide by field value plus one
                if (wrapNow)
                begin
                    divCnt_r       <= {DIV_W{1'b0}};
                    oneHzTickTimer <= 1'b1;
                    oneHzTickCal   <= 1'b1;
                end
                else
                    divCnt_r <= divCnt_r + 15'h0001;
            end
        end
    end

endmodule // rtcc_tick_gen

/* design/rtcc_clock_ctrl.v */
`timescale 1ns/1ps
`include "rtcc_regs.vh"

// What this block does
// - Tick divides slow clock by divider plus one
// - Divider zero: timer tick slow, calendar stopped
// - Divider resets to 32768 cycles per tick
// - Lock set ignores divider and trim writes
// - Trim deletes pulses per 1023-cycle window
// - Trim zero deletes none, maximum deletes all
// - Lock bit locks control until power-on reset
// - Mask bit 0 enables calendar interrupt
// - Mask bit 1 enables countdown interrupt
// - Raw status shows unmasked flags bits 0,1
// - Masked status is raw AND mask
// - Clear register write-one clears each flag
// - Countdown zero event sets raw countdown flag
module rtcc_clock_ctrl #(
    parameter DIV_W  = 15,
    parameter TRIM_W = 10
)(
    input  wire        clk_sys,
    input  wire        nrst,
    input  wire        slowClock,
    input  wire        calendarEvent,
    input  wire        countdownZero,
    output wire        oneHzTickTimer,
    output wire        oneHzTickCal,
    output wire        calendarEnableLock,
    output wire        calendarIrqOut,
    output wire        countdownIrqOut,
    output wire        irqOut,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    reg  [DIV_W-1:0]  tickDivider_r;
    reg  [TRIM_W-1:0] trimDeleteCount_r;
    reg               lock_r;
    reg  [1:0]        irqEnable_r;
    reg  [1:0]        irqRaw_r;
    reg  [1:0]        irqRaw_nxt;
    reg               slowSync1_r;
    reg               slowSync2_r;
    reg               slowPrev_r;
    reg  [7:0]        awAddr_r;
    reg               awHeld_r;
    reg  [31:0]       wData_r;
    reg  [3:0]        wStrb_r;
    reg               wHeld_r;
    reg  [31:0]       rdMux;
    reg               rdHit;
    wire              slowEdge;
    wire              doWrite;
    wire [1:0]        irqMasked;
    wire [1:0]        irqSet;
    wire [1:0]        irqClr;
    wire              wrHit;

    ////////////////////////////////////////////////////////////////////////
    // Slow clock enters on a pin: two flops, then edge detect on the second
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            slowSync1_r <= 1'b0;
            slowSync2_r <= 1'b0;
            slowPrev_r  <= 1'b0;
        end
        else
        begin
            slowSync1_r <= slowClock;
            slowSync2_r <= slowSync1_r;
            slowPrev_r  <= slowSync2_r;
        end
    end

    assign slowEdge = slowSync2_r && !slowPrev_r;

    rtcc_tick_gen #(
        .DIV_W  (DIV_W),
        .TRIM_W (TRIM_W)
    ) u_tick (
        .clk_sys         (clk_sys),
        .nrst            (nrst),
        .slowEdge        (slowEdge),
        .tickDivider     (tickDivider_r),
        .trimDeleteCount (trimDeleteCount_r),
        .oneHzTickTimer  (oneHzTickTimer),
        .oneHzTickCal    (oneHzTickCal)
    );

    ////////////////////////////////////////////////////////////////////////
    // AXI write channel: address and data taken in either order
    assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
    assign doWrite       = awHeld_r && wHeld_r && !s_axi_bvalid;
    assign wrHit         = (awAddr_r[7:2] == `RTCC_OFS_CTRL >> 2)
                        || (awAddr_r[7:2] == `RTCC_OFS_MASK >> 2)
                        || (awAddr_r[7:2] == `RTCC_OFS_CLEAR >> 2);

    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            awAddr_r     <= 8'h00;
            awHeld_r     <= 1'b0;
            wData_r      <= 32'h00000000;
            wStrb_r      <= 4'h0;
            wHeld_r      <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RTCC_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awAddr_r <= s_axi_awaddr;
                awHeld_r <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
                wHeld_r <= 1'b1;
            end
            if (doWrite)
            begin
                awHeld_r     <= 1'b0;
                wHeld_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Read-only and unmapped offsets answer with an error
                s_axi_bresp  <= wrHit ? `RTCC_RESP_OKAY : `RTCC_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and mask registers; byte strobes honoured per lane
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            tickDivider_r     <= `RTCC_DIV_RST;
            trimDeleteCount_r <= `RTCC_TRIM_RST;
            lock_r            <= 1'b0;
            irqEnable_r       <= `RTCC_MASK_RST;
        end
        else if (doWrite)
        begin
            // Once locked, only power-on reset reopens the register
            if (awAddr_r == `RTCC_OFS_CTRL && !lock_r)
            begin
                if (wStrb_r[0])
                    tickDivider_r[7:0] <= wData_r[7:0];
                if (wStrb_r[1])
                    tickDivider_r[14:8] <= wData_r[14:8];
                if (wStrb_r[2])
                    trimDeleteCount_r[7:0] <= wData_r[23:16];
                if (wStrb_r[3])
                begin
                    trimDeleteCount_r[9:8] <= wData_r[25:24];
                    lock_r <= wData_r[`RTCC_LOCK_BIT];
                end
            end
            // Reserved mask bits are simply not stored
            if (awAddr_r == `RTCC_OFS_MASK && wStrb_r[0])
                irqEnable_r <= wData_r[1:0];
        end
    end

    assign calendarEnableLock = lock_r;

    ////////////////////////////////////////////////////////////////////////
    // Sticky raw flags: set wins over a same-cycle clear
    assign irqSet = {countdownZero, calendarEvent};
    assign irqClr = (doWrite && awAddr_r == `RTCC_OFS_CLEAR && wStrb_r[0])
                  ? wData_r[1:0] : 2'b00;

    always @*
    begin
        irqRaw_nxt = (irqRaw_r & ~irqClr) | irqSet;
    end

    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            irqRaw_r <= 2'b00;
        else
            irqRaw_r <= irqRaw_nxt;
    end

    // Masked flags drive the two interrupt lines and the combined one
    assign irqMasked       = irqRaw_r & irqEnable_r;
    assign calendarIrqOut  = irqMasked[`RTCC_IRQ_CAL];
    assign countdownIrqOut = irqMasked[`RTCC_IRQ_CNT];
    assign irqOut          = |irqMasked;

    ////////////////////////////////////////////////////////////////////////
    // Read mux; reserved bits zero, clear register reads zero
    always @*
    begin
        rdMux = 32'h00000000;
        rdHit = 1'b1;
        case (s_axi_araddr[7:2])
            `RTCC_OFS_CTRL >> 2:
            begin
                rdMux[`RTCC_DIV_MSB:`RTCC_DIV_LSB]   = tickDivider_r;
                rdMux[`RTCC_TRIM_MSB:`RTCC_TRIM_LSB] = trimDeleteCount_r;
                rdMux[`RTCC_LOCK_BIT]                = lock_r;
            end
            `RTCC_OFS_MASK >> 2:   rdMux[1:0] = irqEnable_r;
            `RTCC_OFS_RAW >> 2:    rdMux[1:0] = irqRaw_r;
            `RTCC_OFS_MASKED >> 2: rdMux[1:0] = irqMasked;
            `RTCC_OFS_CLEAR >> 2:  rdMux = 32'h00000000;
            default:               rdHit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI read channel: one cycle latency, held until rready
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RTCC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdMux;
            s_axi_rresp  <= rdHit ? `RTCC_RESP_OKAY : `RTCC_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule // rtcc_clock_ctrl

/* tb/rtcc_clock_ctrl_sva.sv */
`timescale 1ns/1ps
`include "rtcc_regs.vh"

// Pin-level checks, bound into the top module
module rtcc_clock_ctrl_sva (
    input logic        clk_sys,
    input logic        nrst,
    input logic        calendarEvent,
    input logic        countdownZero,
    input logic        oneHzTickTimer,
    input logic        calendarEnableLock,
    input logic        calendarIrqOut,
    input logic        countdownIrqOut,
    input logic        irqOut,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [7:0]  s_axi_araddr,
    input logic        s_axi_rvalid,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp,
    input logic        s_axi_bvalid
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////////////
    // Flags move only on an event or at a write completion
    chk_irq_or: assert property (
        irqOut == (calendarIrqOut | countdownIrqOut))
        else $error("irq output is not the OR of masked flags");
    chk_cal_rise: assert property (
        $rose(calendarIrqOut) |-> $past(calendarEvent) || s_axi_bvalid)
        else $error("calendar irq rose without cause");
    chk_cal_fall: assert property ($fell(calendarIrqOut) |-> s_axi_bvalid)
        else $error("calendar irq fell without a write");
    chk_cnt_rise: assert property (
        $rose(countdownIrqOut) |-> $past(countdownZero) || s_axi_bvalid)
        else $error("countdown irq rose without cause");
    chk_cnt_fall: assert property ($fell(countdownIrqOut) |-> s_axi_bvalid)
        else $error("countdown irq fell without a write");
    chk_lock_hold: assert property (
        calendarEnableLock |=> calendarEnableLock)
        else $error("lock bit dropped without reset");

    ////////////////////////////////////////////////////////////////////////////
    // Tick shape and read channel; unmapped reads must not leak data
    chk_tick_pulse: assert property (oneHzTickTimer |=> !oneHzTickTimer)
        else $error("timer tick longer than one cycle");
    chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_unmapped_err: assert property (s_axi_arvalid && s_axi_arready &&
        !(s_axi_araddr inside {`RTCC_OFS_CTRL, `RTCC_OFS_MASK, `RTCC_OFS_RAW,
        `RTCC_OFS_MASKED, `RTCC_OFS_CLEAR}) |=>
        s_axi_rresp == `RTCC_RESP_SLVERR && s_axi_rdata == 32'h00000000)
        else $error("unmapped read not refused");
endmodule // rtcc_clock_ctrl_sva

bind rtcc_clock_ctrl rtcc_clock_ctrl_sva u_sva (.*);

/* tb/rtcc_clock_ctrl_tb.sv */
`timescale 1ns/1ps
`include "rtcc_regs.vh"

module rtcc_clock_ctrl_tb;
    logic        clk_sys = 1'b0;
    logic        nrst = 1'b0;
    logic        calendarEvent = 1'b0;
    logic        countdownZero = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic [4:0]  slowCnt = 5'h00;
    wire         slowClock = slowCnt[4];
    wire         oneHzTickTimer, oneHzTickCal, calendarEnableLock;
    wire         calendarIrqOut, countdownIrqOut, irqOut;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire         s_axi_arready, s_axi_rvalid;
    wire [1:0]   s_axi_bresp, s_axi_rresp;
    wire [31:0]  s_axi_rdata;
    int          n_errors = 0;
    int          samples_checked = 0;
    logic [31:0] rdVal;
    logic [1:0]  rsp;

    rtcc_clock_ctrl DUT (.*);

    // Slow clock of 32 cycles keeps the divider runs short
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) slowCnt <= slowCnt + 5'h01;

    ////////////////////////////////////////////////////////////////////////////
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", samples_checked, n_errors);
            if (n_errors == 0 && samples_checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        begin
            samples_checked++;
            if (seen !== exp)
            begin
                n_errors++;
                $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    // Bounded waits end the run rather than hang
    task guard(input int i);
        begin
            if (i >= 100)
            begin
                n_errors++;
                end_sim;
            end
        end
    endtask

    // Handshakes judged at the falling edge, acted on at the next rise
    task wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        logic awTk;
        logic wTk;
        logic bTk;
        begin
            i = 0;
            bTk = 1'b0;
            @(posedge clk_sys);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            while (!bTk && i < 100)
            begin
                @(negedge clk_sys);
                awTk = s_axi_awvalid && s_axi_awready;
                wTk = s_axi_wvalid && s_axi_wready;
                bTk = s_axi_bvalid;
                rsp = s_axi_bresp;
                @(posedge clk_sys);
                if (awTk) s_axi_awvalid <= 1'b0;
                if (wTk) s_axi_wvalid <= 1'b0;
                i++;
            end
            s_axi_bready <= 1'b0;
            if (!bTk) guard(100);
        end
    endtask

    task rchk(input logic [7:0] a, input logic [31:0] e);
        int i;
        logic arTk;
        logic rTk;
        begin
            i = 0;
            rTk = 1'b0;
            @(posedge clk_sys);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            while (!rTk && i < 100)
            begin
                @(negedge clk_sys);
                arTk = s_axi_arvalid && s_axi_arready;
                rTk = s_axi_rvalid;
                rdVal = s_axi_rdata;
                rsp = s_axi_rresp;
                @(posedge clk_sys);
                if (arTk) s_axi_arvalid <= 1'b0;
                i++;
            end
            s_axi_rready <= 1'b0;
            if (!rTk) guard(100);
            chk(rdVal, e);
        end
    endtask

    // Gap from second to third timer tick; earlier ones may mix old settings
    task tper(input int e, input logic cal);
        int n;
        int k;
        begin
            for (k = 0; k < 3; k++)
            begin
                n = 0;
                do
                begin
                    @(negedge clk_sys);
                    n++;
                end
                while (!oneHzTickTimer && n < 600);
                if (n >= 600) guard(100);
            end
            chk(n, e);
            chk(oneHzTickCal, cal);
        end
    endtask

    task cal_none;
        int n;
        begin
            n = 0;
            repeat (400)
            begin
                @(negedge clk_sys);
                if (oneHzTickCal) n++;
            end
            chk(n, 0);
        end
    endtask

    task do_reset;
        begin
            nrst <= 1'b0;
            repeat (16) @(posedge clk_sys);
            nrst <= 1'b1;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task t_reset;
        begin
            rchk(`RTCC_OFS_CTRL, 32'h00007FFF);
            rchk(`RTCC_OFS_MASK, 32'h00000000);
            rchk(`RTCC_OFS_RAW, 32'h00000000);
            rchk(`RTCC_OFS_MASKED, 32'h00000000);
        end
    endtask

    task t_div;
        begin
            wr(`RTCC_OFS_CTRL, 32'hF8008001);
            rchk(`RTCC_OFS_CTRL, 32'h00000001);
            tper(64, 1'b1);
            wr(`RTCC_OFS_CTRL, 32'h00000003);
            tper(128, 1'b1);
            wr(`RTCC_OFS_CTRL, 32'h00000000);
            tper(32, 1'b0);
            cal_none;
            wr(`RTCC_OFS_CTRL, 32'h03FF0001);
            rchk(`RTCC_OFS_CTRL, 32'h03FF0001);
            cal_none;
        end
    endtask

    task t_irq;
        int b;
        begin
            wr(`RTCC_OFS_MASK, 32'hFFFFFFFF);
            rchk(`RTCC_OFS_MASK, 32'h00000003);
            wr(`RTCC_OFS_MASK, 32'h00000000);
            for (b = 0; b < 2; b++)
            begin
                @(posedge clk_sys);
                calendarEvent <= (b == 0);
                countdownZero <= (b == 1);
                @(posedge clk_sys);
                calendarEvent <= 1'b0;
                countdownZero <= 1'b0;
                rchk(`RTCC_OFS_RAW, 32'h1 << b);
                rchk(`RTCC_OFS_MASKED, 32'h0);
                chk(irqOut, 1'b0);
                wr(`RTCC_OFS_MASK, 32'h1 << b);
                rchk(`RTCC_OFS_MASKED, 32'h1 << b);
                chk({calendarIrqOut, countdownIrqOut, irqOut},
                    {b == 0, b == 1, 1'b1});
                wr(`RTCC_OFS_CLEAR, 32'h0);
                rchk(`RTCC_OFS_RAW, 32'h1 << b);
                wr(`RTCC_OFS_CLEAR, 32'h1 << b);
                rchk(`RTCC_OFS_RAW, 32'h0);
                chk(irqOut, 1'b0);
            end
            wr(`RTCC_OFS_RAW, 32'h3);
            chk(rsp, `RTCC_RESP_SLVERR);
            rchk(8'h00, 32'h0);
            chk(rsp, `RTCC_RESP_SLVERR);
        end
    endtask

    task t_lock;
        begin
            wr(`RTCC_OFS_CTRL, 32'h04000005);
            chk(calendarEnableLock, 1'b1);
            wr(`RTCC_OFS_CTRL, 32'h00020002);
            chk(rsp, `RTCC_RESP_OKAY);
            rchk(`RTCC_OFS_CTRL, 32'h04000005);
            do_reset;
            rchk(`RTCC_OFS_CTRL, 32'h00007FFF);
        end
    endtask

    initial
    begin
        do_reset;
        t_reset;
        t_div;
        t_irq;
        t_lock;
        end_sim;
    end
endmodule // rtcc_clock_ctrl_tb
